// ==== src/atcs_pkg.sv ====
package atcs_pkg;
	localparam logic [7:0] ADDR_COUNT = 8'h00;
	localparam logic [7:0] ADDR_COMPARE = 8'h04;
	localparam logic [7:0] ADDR_CONTROL_A = 8'h08;
	localparam logic [7:0] ADDR_CONTROL_B = 8'h0C;
	localparam logic [7:0] ADDR_ASYNC_STATUS = 8'h10;
	localparam logic [7:0] ADDR_GEN_CTRL = 8'h14;
	localparam logic [7:0] ADDR_IRQ = 8'h18;
	localparam logic [7:0] ADDR_SLEEP = 8'h1C;
	localparam int NUM_SYNC = 3;
	localparam int IDX_COUNT = 0;
	localparam int IDX_COMPARE = 1;
	localparam int IDX_CONTROL = 2;
	localparam logic [7:0] SYNC_ADDR [NUM_SYNC] = '{ADDR_COUNT, ADDR_COMPARE,
		ADDR_CONTROL_A};
	localparam int ASR_ASYNC_BIT = 3;
	localparam int ASR_EXT_BIT = 4;
	localparam int GTC_PRESC_RST_BIT = 0;
	localparam int IRQ_CMP_EN_BIT = 0;
	localparam int IRQ_OVF_EN_BIT = 1;
	localparam int IRQ_CMP_FLAG_BIT = 8;
	localparam int IRQ_OVF_FLAG_BIT = 9;
	localparam int SLP_STALL_BIT = 2;
	localparam logic [7:0] CTLA_MASK = 8'hC3;
	localparam logic [1:0] WGM_CTC = 2'h2;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV32 = 3'h3;
	localparam logic [2:0] CS_DIV64 = 3'h4;
	localparam logic [2:0] CS_DIV128 = 3'h5;
	localparam logic [2:0] CS_DIV256 = 3'h6;
	localparam logic [2:0] CS_DIV1024 = 3'h7;
	localparam logic [9:0] PMASK_DIV8 = 10'h007;
	localparam logic [9:0] PMASK_DIV32 = 10'h01F;
	localparam logic [9:0] PMASK_DIV64 = 10'h03F;
	localparam logic [9:0] PMASK_DIV128 = 10'h07F;
	localparam logic [9:0] PMASK_DIV256 = 10'h0FF;
	localparam logic [9:0] PMASK_DIV1024 = 10'h3FF;
	localparam logic [1:0] SLP_NONE = 2'h0;
	localparam logic [1:0] SLP_IDLE = 2'h1;
	localparam logic [1:0] SLP_SAVE = 2'h2;
	localparam logic [1:0] SLP_DOWN = 2'h3;
	localparam logic [1:0] XFER_EDGES = 2'h2;
	localparam int FLAG_SYNC_CYCLES = 3;
	localparam logic [2:0] WAKE_STALL_CYCLES = 3'h4;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] REG8_RESET = 8'h00;
	typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_STALL} atcs_pwr_type;
endpackage

// ==== src/atcs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module atcs_sync (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_async,
	output logic o_rise
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign o_rise = sync_reg & ~last_reg;
endmodule
`default_nettype wire

// ==== src/atcs_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module atcs_prescaler (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_src_tick,
	input wire logic i_clear,
	input wire logic [2:0] i_sel,
	output logic o_tick
);
	logic [9:0] cnt_reg;
	logic [9:0] mask;

	always_ff @(posedge i_clk) begin
		if (i_rst || i_clear) begin
			cnt_reg <= 10'h000;
		end else if (i_src_tick) begin
			cnt_reg <= cnt_reg + 10'h001;
		end
	end

	always_comb begin
		mask = 10'h000;
		case (i_sel)
			atcs_pkg::CS_DIV8: mask = atcs_pkg::PMASK_DIV8;
			atcs_pkg::CS_DIV32: mask = atcs_pkg::PMASK_DIV32;
			atcs_pkg::CS_DIV64: mask = atcs_pkg::PMASK_DIV64;
			atcs_pkg::CS_DIV128: mask = atcs_pkg::PMASK_DIV128;
			atcs_pkg::CS_DIV256: mask = atcs_pkg::PMASK_DIV256;
			atcs_pkg::CS_DIV1024: mask = atcs_pkg::PMASK_DIV1024;
			default: mask = 10'h000;
		endcase
	end

	assign o_tick = (i_sel != atcs_pkg::CS_STOP) & i_src_tick &
		((cnt_reg & mask) == mask);

	// Phase reset
	a_presc_clear: assert property (@(posedge i_clk) disable iff (i_rst)
		i_clear |=> cnt_reg == 10'h000)
		else $error("prescaler not cleared");
	// Divide by eight
	a_div8_phase: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_sel == atcs_pkg::CS_DIV8) && o_tick |-> cnt_reg[2:0] == 3'h7)
		else $error("divide by eight tick out of phase");
endmodule
`default_nettype wire

// ==== src/atcs_top.sv ====
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module atcs_top (
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic I_ASYNC_OSC_CLK,
	input wire logic I_CRYSTAL_INPUT_PIN,
	input wire logic I_WAKE_PIN,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	output logic O_COMPARE_OUT,
	output logic O_OSC_ENABLE,
	output logic O_CPU_STALL,
	output logic O_TIMER_IRQ
);
	localparam int PW = atcs_pkg::FLAG_SYNC_CYCLES - 1;

	function automatic logic addr_known(input logic [7:0] a);
		case (a)
			atcs_pkg::ADDR_COUNT, atcs_pkg::ADDR_COMPARE,
			atcs_pkg::ADDR_CONTROL_A, atcs_pkg::ADDR_CONTROL_B,
			atcs_pkg::ADDR_ASYNC_STATUS, atcs_pkg::ADDR_GEN_CTRL,
			atcs_pkg::ADDR_IRQ, atcs_pkg::ADDR_SLEEP: addr_known = 1'b1;
			default: addr_known = 1'b0;
		endcase
	endfunction

	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rdata;
	logic acc;
	logic wr;
	logic osc_rise;
	logic pin_rise;
	logic wake_rise;
	logic async_sel_reg;
	logic ext_sel_reg;
	logic [2:0] cs_reg;
	logic presc_clear;
	logic presc_tick;
	logic src_edge;
	logic clk_on;
	logic lost;
	logic [7:0] hold_reg [atcs_pkg::NUM_SYNC];
	logic [1:0] edge_cnt_reg [atcs_pkg::NUM_SYNC];
	logic [atcs_pkg::NUM_SYNC-1:0] busy_reg;
	logic [atcs_pkg::NUM_SYNC-1:0] wr_sync;
	logic [atcs_pkg::NUM_SYNC-1:0] xfer_done;
	logic [7:0] count_reg;
	logic [7:0] compare_reg;
	logic [7:0] ctrl_a_reg;
	logic [7:0] count_read_reg;
	logic match;
	logic overflow;
	logic cmp_out_reg;
	logic [PW-1:0] cmp_pipe_reg;
	logic [PW-1:0] ovf_pipe_reg;
	logic [1:0] flags_reg;
	logic [1:0] en_reg;
	logic [1:0] flag_clr;
	logic irq_cond;
	logic armed_reg;
	logic wake_pend_reg;
	logic irq_reg;
	logic osc_en_reg;
	atcs_pkg::atcs_pwr_type state_reg;
	atcs_pkg::atcs_pwr_type state_next;
	logic [1:0] mode_reg;
	logic [2:0] stall_cnt_reg;
	logic stall_reg;
	logic io_active;

	assign acc = I_PSEL & I_PENABLE & pready_reg;
	assign wr = acc & I_PWRITE;

	atcs_sync u_osc_sync (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.i_async(I_ASYNC_OSC_CLK),
		.o_rise(osc_rise)
	);

	atcs_sync u_pin_sync (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.i_async(I_CRYSTAL_INPUT_PIN),
		.o_rise(pin_rise)
	);

	atcs_sync u_wake_sync (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.i_async(I_WAKE_PIN),
		.o_rise(wake_rise)
	);

	// APB slave with one wait state
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= I_PSEL & I_PENABLE & ~pready_reg;
			if (I_PSEL && I_PENABLE && !pready_reg) begin
				pslverr_reg <= ~addr_known(I_PADDR);
				prdata_reg <= I_PWRITE ? 32'h0000_0000 : rdata;
			end
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		case (I_PADDR)
			atcs_pkg::ADDR_COUNT: rdata[7:0] = count_read_reg;
			atcs_pkg::ADDR_COMPARE: rdata[7:0] = compare_reg;
			atcs_pkg::ADDR_CONTROL_A: rdata[7:0] = ctrl_a_reg & atcs_pkg::CTLA_MASK;
			atcs_pkg::ADDR_CONTROL_B: rdata[2:0] = cs_reg;
			atcs_pkg::ADDR_ASYNC_STATUS: begin
				rdata[atcs_pkg::NUM_SYNC-1:0] = busy_reg;
				rdata[atcs_pkg::ASR_ASYNC_BIT] = async_sel_reg;
				rdata[atcs_pkg::ASR_EXT_BIT] = ext_sel_reg;
			end
			atcs_pkg::ADDR_IRQ: begin
				rdata[atcs_pkg::IRQ_CMP_EN_BIT] = en_reg[0];
				rdata[atcs_pkg::IRQ_OVF_EN_BIT] = en_reg[1];
				rdata[atcs_pkg::IRQ_CMP_FLAG_BIT] = flags_reg[0];
				rdata[atcs_pkg::IRQ_OVF_FLAG_BIT] = flags_reg[1];
			end
			atcs_pkg::ADDR_SLEEP: begin
				rdata[1:0] = mode_reg;
				rdata[atcs_pkg::SLP_STALL_BIT] = stall_reg;
			end
			default: rdata = 32'h0000_0000;
		endcase
	end

	// Clock source and prescaler control
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			async_sel_reg <= 1'b0;
			ext_sel_reg <= 1'b0;
			cs_reg <= atcs_pkg::CS_STOP;
		end else begin
			if (wr && I_PADDR == atcs_pkg::ADDR_ASYNC_STATUS) begin
				async_sel_reg <= I_PWDATA[atcs_pkg::ASR_ASYNC_BIT];
				ext_sel_reg <= I_PWDATA[atcs_pkg::ASR_EXT_BIT];
			end
			if (wr && I_PADDR == atcs_pkg::ADDR_CONTROL_B) begin
				cs_reg <= I_PWDATA[2:0];
			end
		end
	end

	assign presc_clear = wr & (I_PADDR == atcs_pkg::ADDR_GEN_CTRL) &
		I_PWDATA[atcs_pkg::GTC_PRESC_RST_BIT];

	always_comb begin
		if (async_sel_reg) begin
			clk_on = !(state_reg == atcs_pkg::PWR_SLEEP &&
				mode_reg == atcs_pkg::SLP_DOWN);
			src_edge = clk_on & (ext_sel_reg ? pin_rise : osc_rise);
		end else begin
			clk_on = !(state_reg == atcs_pkg::PWR_SLEEP &&
				mode_reg != atcs_pkg::SLP_IDLE);
			src_edge = clk_on;
		end
	end

	atcs_prescaler u_presc (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.i_src_tick(src_edge),
		.i_clear(presc_clear),
		.i_sel(cs_reg),
		.o_tick(presc_tick)
	);

	assign lost = (state_reg == atcs_pkg::PWR_SLEEP) &&
		(mode_reg == atcs_pkg::SLP_DOWN) && wake_rise;

	// Holding registers and busy flags
	genvar gi;
	generate
		for (gi = 0; gi < atcs_pkg::NUM_SYNC; gi++) begin : g_sync
			assign wr_sync[gi] = wr & (I_PADDR == atcs_pkg::SYNC_ADDR[gi]);
			assign xfer_done[gi] = busy_reg[gi] & src_edge &
				(edge_cnt_reg[gi] == atcs_pkg::XFER_EDGES - 2'h1);
			always_ff @(posedge I_CLK) begin
				if (I_SYS_RST || lost) begin
					busy_reg[gi] <= 1'b0;
					edge_cnt_reg[gi] <= 2'h0;
					hold_reg[gi] <= atcs_pkg::REG8_RESET;
				end else if (wr_sync[gi]) begin
					busy_reg[gi] <= 1'b1;
					edge_cnt_reg[gi] <= 2'h0;
					hold_reg[gi] <= I_PWDATA[7:0];
				end else if (xfer_done[gi]) begin
					busy_reg[gi] <= 1'b0;
				end else if (busy_reg[gi] && src_edge) begin
					edge_cnt_reg[gi] <= edge_cnt_reg[gi] + 2'h1;
				end
			end
		end
	endgenerate

	assign match = presc_tick && (count_reg == compare_reg) &&
		!busy_reg[atcs_pkg::IDX_COUNT] && !busy_reg[atcs_pkg::IDX_COMPARE];
	assign overflow = presc_tick && (count_reg == atcs_pkg::COUNT_MAX);

	// Timer side registers
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || lost) begin
			count_reg <= atcs_pkg::REG8_RESET;
			compare_reg <= atcs_pkg::REG8_RESET;
			ctrl_a_reg <= atcs_pkg::REG8_RESET;
		end else begin
			if (xfer_done[atcs_pkg::IDX_COUNT]) begin
				count_reg <= hold_reg[atcs_pkg::IDX_COUNT];
			end else if (match && ctrl_a_reg[1:0] == atcs_pkg::WGM_CTC) begin
				count_reg <= atcs_pkg::REG8_RESET;
			end else if (presc_tick) begin
				count_reg <= count_reg + 8'h01;
			end
			if (xfer_done[atcs_pkg::IDX_COMPARE]) begin
				compare_reg <= hold_reg[atcs_pkg::IDX_COMPARE];
			end
			if (xfer_done[atcs_pkg::IDX_CONTROL]) begin
				ctrl_a_reg <= hold_reg[atcs_pkg::IDX_CONTROL];
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || lost) begin
			cmp_out_reg <= 1'b0;
		end else if (match) begin
			case (ctrl_a_reg[7:6])
				atcs_pkg::COM_TOGGLE: cmp_out_reg <= ~cmp_out_reg;
				atcs_pkg::COM_CLEAR: cmp_out_reg <= 1'b0;
				atcs_pkg::COM_SET: cmp_out_reg <= 1'b1;
				default: cmp_out_reg <= cmp_out_reg;
			endcase
		end
	end

	assign io_active = (state_reg != atcs_pkg::PWR_SLEEP) ||
		(mode_reg == atcs_pkg::SLP_IDLE);
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || lost) begin
			count_read_reg <= atcs_pkg::REG8_RESET;
		end else if (src_edge && io_active) begin
			count_read_reg <= count_reg;
		end
	end

	assign flag_clr[0] = wr & (I_PADDR == atcs_pkg::ADDR_IRQ) &
		I_PWDATA[atcs_pkg::IRQ_CMP_FLAG_BIT];
	assign flag_clr[1] = wr & (I_PADDR == atcs_pkg::ADDR_IRQ) &
		I_PWDATA[atcs_pkg::IRQ_OVF_FLAG_BIT];
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			cmp_pipe_reg <= '0;
			ovf_pipe_reg <= '0;
			flags_reg <= 2'h0;
			en_reg <= 2'h0;
		end else begin
			cmp_pipe_reg <= {cmp_pipe_reg[PW-2:0], match};
			ovf_pipe_reg <= {ovf_pipe_reg[PW-2:0], overflow};
			flags_reg <= (flags_reg & ~flag_clr) |
				{ovf_pipe_reg[PW-1], cmp_pipe_reg[PW-1]};
			if (wr && I_PADDR == atcs_pkg::ADDR_IRQ) begin
				en_reg[0] <= I_PWDATA[atcs_pkg::IRQ_CMP_EN_BIT];
				en_reg[1] <= I_PWDATA[atcs_pkg::IRQ_OVF_EN_BIT];
			end
		end
	end
	assign irq_cond = |(flags_reg & en_reg);

	// Power state machine
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			atcs_pkg::PWR_RUN: begin
				if (wr && I_PADDR == atcs_pkg::ADDR_SLEEP &&
					I_PWDATA[1:0] != atcs_pkg::SLP_NONE) begin
					state_next = atcs_pkg::PWR_SLEEP;
				end
			end
			atcs_pkg::PWR_SLEEP: begin
				if (wake_rise || (wake_pend_reg && src_edge)) begin
					state_next = atcs_pkg::PWR_STALL;
				end
			end
			atcs_pkg::PWR_STALL: begin
				if (stall_cnt_reg == atcs_pkg::WAKE_STALL_CYCLES - 3'h1) begin
					state_next = atcs_pkg::PWR_RUN;
				end
			end
			default: state_next = atcs_pkg::PWR_RUN;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			state_reg <= atcs_pkg::PWR_RUN;
			mode_reg <= atcs_pkg::SLP_NONE;
			stall_cnt_reg <= 3'h0;
			stall_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			stall_reg <= state_next != atcs_pkg::PWR_RUN;
			if (state_reg == atcs_pkg::PWR_RUN &&
				state_next == atcs_pkg::PWR_SLEEP) begin
				mode_reg <= I_PWDATA[1:0];
			end else if (state_next == atcs_pkg::PWR_RUN) begin
				mode_reg <= atcs_pkg::SLP_NONE;
			end
			if (state_reg == atcs_pkg::PWR_STALL) begin
				stall_cnt_reg <= stall_cnt_reg + 3'h1;
			end else begin
				stall_cnt_reg <= 3'h0;
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			armed_reg <= 1'b1;
			wake_pend_reg <= 1'b0;
		end else begin
			if (state_reg == atcs_pkg::PWR_SLEEP &&
				state_next == atcs_pkg::PWR_STALL) begin
				armed_reg <= 1'b0;
			end else if (src_edge) begin
				armed_reg <= 1'b1;
			end
			if (state_reg != atcs_pkg::PWR_SLEEP) begin
				wake_pend_reg <= 1'b0;
			end else if (irq_cond && armed_reg &&
				mode_reg != atcs_pkg::SLP_DOWN) begin
				wake_pend_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			osc_en_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			osc_en_reg <= async_sel_reg && !(state_next == atcs_pkg::PWR_SLEEP &&
				(state_reg == atcs_pkg::PWR_SLEEP ? mode_reg : I_PWDATA[1:0]) ==
				atcs_pkg::SLP_DOWN);
			irq_reg <= irq_cond & armed_reg;
		end
	end

	assign O_PRDATA = prdata_reg;
	assign O_PREADY = pready_reg;
	assign O_PSLVERR = pslverr_reg;
	assign O_COMPARE_OUT = cmp_out_reg;
	assign O_OSC_ENABLE = osc_en_reg;
	assign O_CPU_STALL = stall_reg;
	assign O_TIMER_IRQ = irq_reg;

	sequence s_wake_start;
		state_reg == atcs_pkg::PWR_SLEEP ##1 state_reg == atcs_pkg::PWR_STALL;
	endsequence
	sequence s_stall_done;
		(state_reg == atcs_pkg::PWR_STALL)[*4] ##1 state_reg == atcs_pkg::PWR_RUN;
	endsequence

	a_busy_on_write: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		wr_sync[atcs_pkg::IDX_COMPARE] && !lost |=> busy_reg[atcs_pkg::IDX_COMPARE])
		else $error("busy not set by write");
	a_landed_value: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		xfer_done[atcs_pkg::IDX_COMPARE] && !wr_sync[atcs_pkg::IDX_COMPARE] &&
		!lost |=> !busy_reg[atcs_pkg::IDX_COMPARE] &&
		compare_reg == $past(hold_reg[atcs_pkg::IDX_COMPARE]))
		else $error("compare value did not land");
	a_no_disturb: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		wr_sync[atcs_pkg::IDX_COUNT] && busy_reg[atcs_pkg::IDX_COMPARE] &&
		!xfer_done[atcs_pkg::IDX_COMPARE] && !lost |=>
		busy_reg[atcs_pkg::IDX_COMPARE] &&
		$stable(hold_reg[atcs_pkg::IDX_COMPARE]))
		else $error("count write disturbed compare transfer");
	a_match_blocked: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		busy_reg[atcs_pkg::IDX_COUNT] || busy_reg[atcs_pkg::IDX_COMPARE] |->
		!match)
		else $error("match during pending transfer");
	a_stall_four: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		s_wake_start |-> s_stall_done)
		else $error("stall not four cycles");
	a_flag_delay: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		match |-> ##3 flags_reg[0])
		else $error("compare flag late");
	a_osc_down: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		state_reg == atcs_pkg::PWR_SLEEP && mode_reg == atcs_pkg::SLP_DOWN &&
		$past(state_reg == atcs_pkg::PWR_SLEEP) |-> !O_OSC_ENABLE)
		else $error("oscillator on in power-down");
	a_lost_wipe: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		lost |=> count_reg == atcs_pkg::REG8_RESET && busy_reg == '0)
		else $error("timer state kept across power-down");
	a_read_frozen: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		!io_active && !lost |=> $stable(count_read_reg))
		else $error("count copy moved during sleep");
endmodule
`default_nettype wire

// ==== src/atcs_fix_note.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== dv/atcs_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module atcs_cpu_model (
	input wire logic i_clk,
	input wire logic [31:0] i_prdata,
	input wire logic i_pready,
	input wire logic i_pslverr,
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [7:0] o_paddr,
	output logic [31:0] o_pwdata,
	output logic o_hang
);
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h00000000;
		o_hang = 1'b0;
	end
	// Request held until pready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge i_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_clk);
		o_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_pready !== 1'b1 && n < 64);
		if (n >= 64)
			o_hang <= 1'b1;
		r = i_prdata;
		e = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		// Released lines do not keep the last value
		o_paddr <= ~a;
		o_pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ==== dv/async_timer_clock_sync_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
	tests_run++; \
	if ((got) !== (ex)) begin \
		err_count++; \
		$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
	end \
end
module async_timer_clock_sync_tb_top;
	logic clk = 1'b0, rst = 1'b1, osc = 1'b0, xin = 1'b0, wake = 1'b0;
	logic osc_on = 1'b1, xin_on = 1'b1;
	logic psel, pen, pwr, slverr, ready, cmp, oen, stall, irq, hang;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic e;
	int err_count = 0, tests_run = 0;
	atcs_cpu_model u_cpu (.i_clk(clk), .i_prdata(prdata), .i_pready(ready),
		.i_pslverr(slverr), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
		.o_paddr(paddr), .o_pwdata(pwdata), .o_hang(hang));
	atcs_top dut (.I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.I_ASYNC_OSC_CLK(osc), .I_CRYSTAL_INPUT_PIN(xin), .I_WAKE_PIN(wake),
		.O_PRDATA(prdata), .O_PREADY(ready), .O_PSLVERR(slverr),
		.O_COMPARE_OUT(cmp), .O_OSC_ENABLE(oen), .O_CPU_STALL(stall),
		.O_TIMER_IRQ(irq));
	initial forever #4 clk = ~clk;
	// model oscillator is stable from time zero
	// timer clocks well below a quarter of the processor clock
	initial forever begin
		#28;
		if (osc_on)
			osc = ~osc;
	end
	initial forever begin
		#36;
		if (xin_on)
			xin = ~xin;
	end
	always @(posedge hang) begin
		err_count++;
		results();
	end
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_cpu.xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a);
		u_cpu.xfer(1'b0, a, 32'h00000000, r, e);
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return irq;
			1: return stall;
			default: return cmp;
		endcase
	endfunction
	// Bounded wait for a port level, returns cycles used
	task automatic wait_lvl(input int k, input logic lvl, output int n);
		n = 0;
		while (sig(k) !== lvl) begin
			@(posedge clk);
			n++;
			if (n > 3000) begin
				err_count++;
				results();
			end
		end
	endtask
	task automatic wait_busy();
		int n;
		n = 0;
		do begin
			rd(atcs_pkg::ADDR_ASYNC_STATUS);
			n++;
		end while (r[2:0] !== 3'h0 && n < 100);
		`CHK("busy cleared", 3'h0, r[2:0])
		if (r[2:0] !== 3'h0)
			results();
	endtask
	task automatic t_reset();
		rd(atcs_pkg::ADDR_ASYNC_STATUS);
		`CHK("status reset", 32'h00000000, r)
		rd(8'h20);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h00000000, r)
		wr(atcs_pkg::ADDR_COMPARE, 32'h0000005A);
		rd(atcs_pkg::ADDR_COMPARE);
		`CHK("sync compare", 32'h0000005A, r)
		$display("test reset done");
	endtask
	task automatic t_async();
		xin_on = 1'b0;
		wr(atcs_pkg::ADDR_IRQ, 32'h00000000);
		wr(atcs_pkg::ADDR_ASYNC_STATUS, 32'h00000008);
		wr(atcs_pkg::ADDR_COMPARE, 32'h00000033);
		wr(atcs_pkg::ADDR_COUNT, 32'h00000010);
		rd(atcs_pkg::ADDR_ASYNC_STATUS);
		`CHK("two busy", 4'hB, r[3:0])
		wait_busy();
		wr(atcs_pkg::ADDR_IRQ, 32'h00000300);
		rd(atcs_pkg::ADDR_COMPARE);
		`CHK("async compare", 32'h00000033, r)
		rd(atcs_pkg::ADDR_COUNT);
		`CHK("async count", 32'h00000010, r)
		xin_on = 1'b1;
		$display("test async done");
	endtask
	task automatic t_ext();
		osc_on = 1'b0;
		wr(atcs_pkg::ADDR_ASYNC_STATUS, 32'h00000018);
		wr(atcs_pkg::ADDR_CONTROL_A, 32'h000000C2);
		rd(atcs_pkg::ADDR_ASYNC_STATUS);
		`CHK("ext busy", 5'h1C, r[4:0])
		wait_busy();
		rd(atcs_pkg::ADDR_CONTROL_A);
		`CHK("ext control", 32'h000000C2, r)
		osc_on = 1'b1;
		wr(atcs_pkg::ADDR_ASYNC_STATUS, 32'h00000000);
		$display("test external done");
	endtask
	task automatic t_presc();
		int d [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
		int hi;
		for (int c = 0; c < 8; c++) begin
			wr(atcs_pkg::ADDR_CONTROL_B, 32'h00000000);
			wr(atcs_pkg::ADDR_CONTROL_A, 32'h00000000);
			wr(atcs_pkg::ADDR_COUNT, 32'h00000000);
			wr(atcs_pkg::ADDR_GEN_CTRL, 32'h00000001);
			wr(atcs_pkg::ADDR_CONTROL_B, 32'(c));
			repeat ((c == 0) ? 64 : 16 * d[c]) @(posedge clk);
			rd(atcs_pkg::ADDR_COUNT);
			hi = (c == 0) ? 0 : ((c == 1) ? 24 : 17);
			`CHK("count low", 1'b1, (c == 0 || r >= 15))
			`CHK("count high", 1'b1, (r <= hi))
		end
		wr(atcs_pkg::ADDR_CONTROL_B, 32'h00000000);
		$display("test prescaler done");
	endtask
	task automatic t_irq();
		int n;
		wr(atcs_pkg::ADDR_COUNT, 32'h000000F0);
		wr(atcs_pkg::ADDR_IRQ, 32'h00000002);
		wr(atcs_pkg::ADDR_CONTROL_B, 32'h00000001);
		wait_lvl(0, 1'b1, n);
		rd(atcs_pkg::ADDR_IRQ);
		`CHK("ovf flag", 1'b1, r[9])
		wr(atcs_pkg::ADDR_CONTROL_B, 32'h00000000);
		wr(atcs_pkg::ADDR_IRQ, 32'h00000202);
		rd(atcs_pkg::ADDR_IRQ);
		`CHK("flag cleared", 1'b0, r[9])
		`CHK("irq low", 1'b0, irq)
		$display("test irq done");
	endtask
	task automatic t_cmp();
		int n;
		wr(atcs_pkg::ADDR_COUNT, 32'h00000000);
		wr(atcs_pkg::ADDR_COMPARE, 32'h00000003);
		wr(atcs_pkg::ADDR_CONTROL_A, 32'h00000042);
		wr(atcs_pkg::ADDR_CONTROL_B, 32'h00000001);
		wait_lvl(2, ~cmp, n);
		wait_lvl(2, ~cmp, n);
		`CHK("toggle period", 4, n)
		wr(atcs_pkg::ADDR_CONTROL_B, 32'h00000000);
		$display("test compare out done");
	endtask
	task automatic wake_up();
		int n;
		wake <= 1'b1;
		repeat (4) @(posedge clk);
		wake <= 1'b0;
		wait_lvl(1, 1'b0, n);
	endtask
	task automatic t_sleep();
		wr(atcs_pkg::ADDR_ASYNC_STATUS, 32'h00000008);
		wr(atcs_pkg::ADDR_COMPARE, 32'h00000077);
		wait_busy();
		wr(atcs_pkg::ADDR_SLEEP, 32'h00000001);
		repeat (2) @(posedge clk);
		`CHK("osc idle", 1'b1, oen)
		`CHK("stall idle", 1'b1, stall)
		wake_up();
		wr(atcs_pkg::ADDR_SLEEP, 32'h00000003);
		repeat (2) @(posedge clk);
		`CHK("osc down", 1'b0, oen)
		wake_up();
		rd(atcs_pkg::ADDR_COMPARE);
		`CHK("compare wiped", 32'h00000000, r)
		$display("test sleep done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_async();
		t_ext();
		t_presc();
		t_irq();
		t_cmp();
		t_sleep();
		results();
	end
endmodule
`default_nettype wire
